/* src/tx_sup_cfg.svh */
/*
  constants for the transmit supervision timers: clock ratios, timer limits
  in bit times and heartbeat counts.
  assumes it is included by bare name from files under src/.
*/
`ifndef TX_SUP_CFG_SVH
`define TX_SUP_CFG_SVH

// ----------------------------------------------------------------------------
// bit clock division
// ----------------------------------------------------------------------------
`define TXS_DIV_W 4
`define TXS_RATIO_8X 4'h8
`define TXS_RATIO_6X 4'h6

// ----------------------------------------------------------------------------
// timer limits in bit times
// ----------------------------------------------------------------------------
`define TXS_JAB_W 17
`define TXS_JABBER_BITS 17'h18a88
`define TXS_LOOP_JABBER_BITS 17'h00145
`define TXS_ECHO_W 9
`define TXS_ECHO_BITS 9'h1fe
`define TXS_HB_W 3
`define TXS_HB_DELAY 3'h7
`define TXS_HB_HOLD 3'h7

`endif

/* src/tx_sup_pkg.sv */
/*
  types shared by the transmit supervision timers.
  assumes nothing beyond a SystemVerilog compiler.
*/
package tx_sup_pkg;

  // --------------------------------------------------------------------------
  // heartbeat sequencer states, one-hot
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    HB_IDLE = 3'b001,
    HB_WAIT = 3'b010,
    HB_ASSERT = 3'b100
  } hb_state_t;

  // --------------------------------------------------------------------------
  // collision sources
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic jabber;
    logic echo;
    logic heartbeat;
  } coll_src_t;

endpackage : tx_sup_pkg

/* src/bit_tick_divider.sv */
/*
  divides the reference clock into one bit time: a tick pulse and a
  registered bit clock.
  assumes the reference clock is the module clock and i_ratio_sel is synchronous.
*/
`timescale 1ns/1ps
`include "tx_sup_cfg.svh"

module bit_tick_divider (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_ratio_sel,
  output logic o_bit_tick,
  output logic o_tx_bit_clock
);

  logic [`TXS_DIV_W-1:0] div_cnt;
  wire [`TXS_DIV_W-1:0] ratio = i_ratio_sel ? `TXS_RATIO_6X : `TXS_RATIO_8X;
  wire div_last = (div_cnt >= ratio - 4'h1);
  wire [`TXS_DIV_W-1:0] next_div_cnt = div_last ? 4'h0 : div_cnt + 4'h1;
  wire next_clock = (div_cnt < (ratio >> 1)) || div_last;

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_cnt <= 4'h0;
      o_bit_tick <= 1'b0;
      o_tx_bit_clock <= 1'b0;
    end else if (i_ce) begin
      div_cnt <= next_div_cnt;
      o_bit_tick <= div_last;
      o_tx_bit_clock <= next_clock;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_div_range: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    div_cnt < `TXS_RATIO_8X) else $error("divider count out of range");
  a_tick_spacing: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_bit_tick && i_ce && !i_ratio_sel |=> !o_bit_tick) else $error("ticks too close");

endmodule : bit_tick_divider

/* src/tx_supervision_timers.sv */
/*
  transmit supervision: collision hold, heartbeat, jabber watchdog and echo
  timer for a station encoder/decoder.
  assumes all inputs are synchronous to i_mclk, which is the reference clock,
  and that enable inputs are already in active-high form.
*/
`timescale 1ns/1ps
`include "tx_sup_cfg.svh"

module tx_supervision_timers #(
  parameter logic [`TXS_JAB_W-1:0] JABBER_BITS = `TXS_JABBER_BITS,
  parameter logic [`TXS_JAB_W-1:0] LOOP_JABBER_BITS = `TXS_LOOP_JABBER_BITS,
  parameter logic [`TXS_ECHO_W-1:0] ECHO_BITS = `TXS_ECHO_BITS
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_ctrl_tx_enable,
  input wire logic i_rx_valid_out,
  input wire logic i_loopback_sel_n,
  input wire logic i_clock_ratio_sel,
  input wire logic i_echo_enable,
  output logic o_collision_out,
  output logic o_line_tx_enable_n,
  output logic o_internal_tx_active,
  output logic o_tx_bit_clock,
  output tx_sup_pkg::coll_src_t o_coll_src
);

  // --------------------------------------------------------------------------
  // elaboration checks
  // --------------------------------------------------------------------------
  if (JABBER_BITS == 17'h0 || LOOP_JABBER_BITS == 17'h0 || ECHO_BITS == 9'h0) begin : g_bad
    $error("timer limits must be nonzero");
  end

  // --------------------------------------------------------------------------
  // bit time
  // --------------------------------------------------------------------------
  logic bit_tick;

  bit_tick_divider u_div (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_ce(i_ce),
    .i_ratio_sel(i_clock_ratio_sel),
    .o_bit_tick(bit_tick),
    .o_tx_bit_clock(o_tx_bit_clock)
  );

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  logic tx_active;
  logic [`TXS_JAB_W-1:0] jab_cnt;
  logic jabber_trip;
  logic [`TXS_ECHO_W-1:0] echo_cnt;
  logic echo_seen;
  logic echo_trip;
  logic coll_hold;
  tx_sup_pkg::hb_state_t hb_state;
  logic [`TXS_HB_W-1:0] hb_cnt;

  // --------------------------------------------------------------------------
  // jabber watchdog
  // --------------------------------------------------------------------------
  wire loopback = !i_loopback_sel_n;
  wire [`TXS_JAB_W-1:0] jab_limit = loopback ? LOOP_JABBER_BITS : JABBER_BITS;
  wire jab_run = tx_active && bit_tick && (jab_cnt < jab_limit);
  wire jab_expire = tx_active && (jab_cnt >= jab_limit);
  wire [`TXS_JAB_W-1:0] next_jab_cnt =
    !tx_active ? 17'h0 : (jab_run ? jab_cnt + 17'h1 : jab_cnt);
  wire next_jabber_trip = tx_active && (jabber_trip || jab_expire);

  // --------------------------------------------------------------------------
  // echo timer
  // --------------------------------------------------------------------------
  wire echo_run = tx_active && !echo_seen && bit_tick && (echo_cnt < ECHO_BITS);
  wire echo_expire = tx_active && !echo_seen && i_echo_enable
    && (echo_cnt >= ECHO_BITS);
  wire [`TXS_ECHO_W-1:0] next_echo_cnt =
    !tx_active ? 9'h0 : (echo_run ? echo_cnt + 9'h1 : echo_cnt);
  wire next_echo_seen = tx_active && (echo_seen || i_rx_valid_out);
  wire next_echo_trip = echo_expire;

  // --------------------------------------------------------------------------
  // collision hold: a new event wins over the release
  // --------------------------------------------------------------------------
  wire coll_set = jab_expire || echo_expire;
  wire coll_release = !i_ctrl_tx_enable && !i_rx_valid_out;
  wire next_coll_hold = coll_set || (coll_hold && !coll_release);

  // --------------------------------------------------------------------------
  // heartbeat sequencer
  // --------------------------------------------------------------------------
  wire tx_fall = tx_active && !i_ctrl_tx_enable;
  wire hb_cnt_done = (hb_state == tx_sup_pkg::HB_WAIT) ? (hb_cnt == `TXS_HB_DELAY)
    : (hb_cnt == `TXS_HB_HOLD);
  tx_sup_pkg::hb_state_t next_hb_state;

  always_comb begin
    next_hb_state = hb_state;
    case (hb_state)
      tx_sup_pkg::HB_IDLE: begin
        if (tx_fall) begin
          next_hb_state = tx_sup_pkg::HB_WAIT;
        end
      end
      tx_sup_pkg::HB_WAIT: begin
        if (i_ctrl_tx_enable) begin
          next_hb_state = tx_sup_pkg::HB_IDLE;
        end else if (bit_tick && hb_cnt_done) begin
          next_hb_state = tx_sup_pkg::HB_ASSERT;
        end
      end
      tx_sup_pkg::HB_ASSERT: begin
        if (bit_tick && hb_cnt_done) begin
          next_hb_state = tx_sup_pkg::HB_IDLE;
        end
      end
      default: begin
        next_hb_state = tx_sup_pkg::HB_IDLE;
      end
    endcase
  end

  wire hb_state_change = (next_hb_state != hb_state);
  wire [`TXS_HB_W-1:0] next_hb_cnt = hb_state_change ? 3'h0
    : (bit_tick ? hb_cnt + 3'h1 : hb_cnt);
  wire hb_active = (hb_state == tx_sup_pkg::HB_ASSERT);

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  wire next_collision = next_coll_hold || (next_hb_state == tx_sup_pkg::HB_ASSERT);
  wire next_line_tx_enable_n = !(i_ctrl_tx_enable && !next_jabber_trip && !loopback);
  tx_sup_pkg::coll_src_t next_coll_src;
  assign next_coll_src = '{jabber: next_jabber_trip, echo: next_echo_trip,
    heartbeat: (next_hb_state == tx_sup_pkg::HB_ASSERT)};

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_active <= 1'b0;
      jab_cnt <= 17'h0;
      jabber_trip <= 1'b0;
      echo_cnt <= 9'h0;
      echo_seen <= 1'b0;
      echo_trip <= 1'b0;
      coll_hold <= 1'b0;
    end else if (i_ce) begin
      tx_active <= i_ctrl_tx_enable;
      jab_cnt <= next_jab_cnt;
      jabber_trip <= next_jabber_trip;
      echo_cnt <= next_echo_cnt;
      echo_seen <= next_echo_seen;
      echo_trip <= next_echo_trip;
      coll_hold <= next_coll_hold;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      hb_state <= tx_sup_pkg::HB_IDLE;
      hb_cnt <= 3'h0;
    end else if (i_ce) begin
      hb_state <= next_hb_state;
      hb_cnt <= next_hb_cnt;
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_collision_out <= 1'b0;
      o_line_tx_enable_n <= 1'b1;
      o_internal_tx_active <= 1'b0;
      o_coll_src <= '0;
    end else if (i_ce) begin
      o_collision_out <= next_collision;
      o_line_tx_enable_n <= next_line_tx_enable_n;
      o_internal_tx_active <= i_ctrl_tx_enable;
      o_coll_src <= next_coll_src;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  a_hold_until_idle: assert property (
    i_ce && coll_hold && !coll_release |=> coll_hold && o_collision_out)
    else $error("collision released while enables active");

  a_hold_release: assert property (
    i_ce && coll_hold && coll_release && !coll_set |=> !coll_hold)
    else $error("collision hold not released");

  a_hb_hold_len: assert property (
    i_ce && hb_active && !(bit_tick && hb_cnt == `TXS_HB_HOLD)
    |=> hb_active && o_collision_out)
    else $error("heartbeat collision ended early");

  a_hb_end: assert property (
    i_ce && hb_active && bit_tick && hb_cnt == `TXS_HB_HOLD
    |=> hb_state == tx_sup_pkg::HB_IDLE)
    else $error("heartbeat collision ran long");

  a_jab_cap: assert property (
    jab_cnt <= jab_limit || !i_ce || $changed(i_loopback_sel_n))
    else $error("watchdog count passed its limit");

  a_jab_clear: assert property (
    i_ce && !tx_active |=> jab_cnt == 17'h0)
    else $error("watchdog count not cleared");

  a_jab_start: assert property (
    i_ce && tx_active && bit_tick && jab_cnt < jab_limit
    |=> jab_cnt == $past(jab_cnt) + 17'h1)
    else $error("watchdog did not advance");

  a_tx_follow: assert property (
    i_ce |=> o_internal_tx_active == $past(i_ctrl_tx_enable)
    && tx_active == o_internal_tx_active)
    else $error("internal transmit does not follow enable");

  a_jab_cutoff: assert property (
    i_ce && jab_expire |=> o_line_tx_enable_n && o_collision_out)
    else $error("jabber timeout without cutoff");

  a_jab_stay_off: assert property (
    i_ce && jabber_trip && tx_active |=> o_line_tx_enable_n)
    else $error("line enabled again after jabber cutoff");

  a_line_idle: assert property (
    i_ce && !i_ctrl_tx_enable |=> o_line_tx_enable_n)
    else $error("line enabled without transmit enable");

  a_loop_limit: assert property (
    loopback && tx_active && jab_cnt == LOOP_JABBER_BITS |-> jab_expire)
    else $error("loopback watchdog limit missed");

  a_echo_cap: assert property (
    echo_cnt <= ECHO_BITS)
    else $error("echo count passed its limit");

  a_echo_stop: assert property (
    i_ce && tx_active && echo_seen |=> echo_cnt == $past(echo_cnt) && !echo_trip)
    else $error("echo timer ran after echo seen");

  a_echo_start: assert property (
    i_ce && $rose(tx_active) |-> echo_cnt == 9'h0)
    else $error("echo timer not fresh at start");

  a_echo_step: assert property (
    i_ce && echo_run |=> echo_cnt == $past(echo_cnt) + 9'h1)
    else $error("echo timer did not advance");

  a_echo_flag: assert property (
    i_ce && echo_expire |=> o_collision_out ##0 o_coll_src.echo)
    else $error("echo timeout without collision");

  a_echo_off: assert property (
    !i_echo_enable && i_ce |=> !echo_trip)
    else $error("disabled echo timer raised collision");

  a_src_echo_off: assert property (
    i_ce && !i_echo_enable |=> !o_coll_src.echo)
    else $error("disabled echo timer shown as source");

  a_hb_start: assert property (
    i_ce && hb_state == tx_sup_pkg::HB_IDLE && tx_fall
    |=> hb_state == tx_sup_pkg::HB_WAIT && hb_cnt == 3'h0)
    else $error("heartbeat wait not started");

  a_hb_delay: assert property (
    i_ce && hb_state == tx_sup_pkg::HB_WAIT && !i_ctrl_tx_enable
    && bit_tick && hb_cnt == `TXS_HB_DELAY |=> hb_active)
    else $error("heartbeat not raised on time");

  a_hb_cancel: assert property (
    i_ce && hb_state == tx_sup_pkg::HB_WAIT && i_ctrl_tx_enable
    |=> hb_state == tx_sup_pkg::HB_IDLE)
    else $error("heartbeat wait not cancelled");

  a_loop_line_off: assert property (
    i_ce && loopback |=> o_line_tx_enable_n)
    else $error("line enabled during loopback");

  c_jabber: cover property (o_coll_src.jabber);
  c_echo: cover property (o_coll_src.echo);
  c_heartbeat: cover property (hb_active ##1 !hb_active);
  c_loop_jabber: cover property (loopback && jab_expire);
  c_echo_seen: cover property (tx_active && echo_seen && i_echo_enable);

endmodule : tx_supervision_timers

/* bench/ctrl_model.sv */
/*
  controller model: raises the transmit enable on request, holds it for a
  given number of bit clocks and backs off as soon as collision is seen.
  assumes it shares the reference clock and reset with the supervision block.
*/
`timescale 1ns/1ps

module ctrl_model (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_go,
  input wire logic [11:0] i_bits,
  input wire logic i_tx_bit_clock,
  input wire logic i_collision_out,
  output logic o_ctrl_tx_enable
);
  // --------------------------------------------------------------------------
  // frame sequencing, driven off the falling edge
  // --------------------------------------------------------------------------
  logic [11:0] n;
  logic clk_d;
  always @(negedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ctrl_tx_enable <= 1'b0;
      n <= 12'h000;
      clk_d <= 1'b0;
    end else begin
      clk_d <= i_tx_bit_clock;
      if (i_go && !o_ctrl_tx_enable) begin
        o_ctrl_tx_enable <= 1'b1;
        n <= 12'h000;
      end else if (o_ctrl_tx_enable) begin
        if (i_tx_bit_clock && !clk_d) begin
          n <= n + 12'h001;
        end
        if (n == i_bits || i_collision_out) begin
          o_ctrl_tx_enable <= 1'b0;
        end
      end
    end
  end
endmodule : ctrl_model

/* bench/tb.sv */
/*
  self-checking bench for the transmit supervision timers.
  assumes short jabber and echo limits set through the parameters.
*/
`timescale 1ns/1ps

module tb;
  // --------------------------------------------------------------------------
  // stimulus and wiring
  // --------------------------------------------------------------------------
  localparam int JB = 20;
  localparam int EB = 12;
  localparam int LB = 325;
  logic i_mclk = 1'b0;
  logic i_rst_n = 1'b0;
  logic go = 1'b0;
  logic rx = 1'b0;
  logic lb_n = 1'b1;
  logic ratio = 1'b0;
  logic echo_en = 1'b0;
  logic ce = 1'b1;
  logic [11:0] bits = 12'h000;
  logic coll, line_n, txa, bclk, tx_en;
  tx_sup_pkg::coll_src_t src;
  int n_mismatch = 0;
  int tests_run = 0;
  int n;

  initial forever #2 i_mclk = ~i_mclk;

  tx_supervision_timers #(.JABBER_BITS(17'h00014), .ECHO_BITS(9'h00c))
    tx_supervision_timers_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(ce),
    .i_ctrl_tx_enable(tx_en), .i_rx_valid_out(rx), .i_loopback_sel_n(lb_n),
    .i_clock_ratio_sel(ratio), .i_echo_enable(echo_en), .o_collision_out(coll),
    .o_line_tx_enable_n(line_n), .o_internal_tx_active(txa),
    .o_tx_bit_clock(bclk), .o_coll_src(src));

  ctrl_model ctrl_model_inst (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_go(go),
    .i_bits(bits), .i_tx_bit_clock(bclk), .i_collision_out(coll),
    .o_ctrl_tx_enable(tx_en));

  // --------------------------------------------------------------------------
  // shared tasks
  // --------------------------------------------------------------------------
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim

  task cyc(input int k);
    repeat (k) @(negedge i_mclk);
  endtask : cyc

  task wait_coll(input logic v, input int lim, output int c);
    c = 0;
    while (coll !== v) begin
      if (c == lim) begin
        chk("wait timeout", 1, 0);
        end_sim;
      end
      cyc(1);
      c++;
    end
  endtask : wait_coll

  task wait_bclk(input logic v, inout int c);
    while (bclk !== v) begin
      if (c >= 24) begin
        chk("bit clock timeout", 1, 0);
        end_sim;
      end
      cyc(1);
      c++;
    end
  endtask : wait_bclk

  task frame(input logic [11:0] b);
    bits <= b;
    go <= 1'b1;
    cyc(1);
    go <= 1'b0;
  endtask : frame

  task in_rng(input string nm, input int v, input int lo, input int hi);
    chk(nm, (v >= lo && v <= hi), 1);
  endtask : in_rng

  // --------------------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------------------
  task t_ratio;
    for (int r = 0; r < 2; r++) begin
      ratio <= r[0];
      cyc(20);
      wait_coll(0, 4, n);
      n = 0;
      wait_bclk(1'b0, n);
      wait_bclk(1'b1, n);
      cyc(1);
      n = 1;
      wait_bclk(1'b0, n);
      wait_bclk(1'b1, n);
      chk("bit period", n, r ? 6 : 8);
    end
    ratio <= 1'b0;
    cyc(10);
  endtask : t_ratio

  task t_jabber_hb;
    for (int k = 0; k < 2; k++) begin
      frame(12'hfff);
      cyc(2);
      chk("line en", line_n, 0);
      chk("tx active", txa, 1);
      wait_coll(1, 400, n);
      in_rng("jabber time", n, JB * 8 - 8, JB * 8 + 8);
      chk("jabber src", src.jabber, 1);
      chk("line cut", line_n, 1);
      wait_coll(0, 6, n);
      wait_coll(1, 100, n);
      in_rng("hb delay", n, 52, 76);
      chk("hb src", src.heartbeat, 1);
      wait_coll(0, 100, n);
      in_rng("hb hold", n, 62, 66);
      cyc(10);
    end
  endtask : t_jabber_hb

  task t_freeze;
    logic b;
    frame(12'hfff);
    cyc(2);
    ce <= 1'b0;
    cyc(1);
    b = bclk;
    cyc(39);
    chk("frozen clock", bclk, b);
    ce <= 1'b1;
    wait_coll(1, 400, n);
    in_rng("frozen jabber", n, JB * 8 - 8, JB * 8 + 8);
    wait_coll(0, 6, n);
    cyc(200);
  endtask : t_freeze

  task t_echo_hold;
    echo_en <= 1'b1;
    frame(12'hfff);
    wait_coll(1, 400, n);
    in_rng("echo time", n, EB * 8 - 8, EB * 8 + 8);
    chk("echo src", src, 3'b010);
    rx <= 1'b1;
    cyc(40);
    chk("hold", coll, 1);
    chk("hold src", src.heartbeat, 0);
    rx <= 1'b0;
    cyc(200);
    chk("released", coll, 0);
  endtask : t_echo_hold

  task t_no_coll(input logic en, input logic rx_on);
    logic seen;
    seen = 1'b0;
    echo_en <= en;
    frame(12'h010);
    cyc(24);
    rx <= rx_on;
    repeat (16 * 8 - 30) begin
      seen = seen | coll;
      cyc(1);
    end
    chk("no collision", seen, 0);
    rx <= 1'b0;
    cyc(200);
  endtask : t_no_coll

  task t_loop;
    lb_n <= 1'b0;
    ratio <= 1'b1;
    echo_en <= 1'b0;
    cyc(10);
    frame(12'hfff);
    cyc(3);
    chk("loop line en", line_n, 1);
    wait_coll(1, 2100, n);
    in_rng("loop jabber", n, LB * 6 - 8, LB * 6 + 8);
    chk("loop src", src.jabber, 1);
    cyc(200);
    lb_n <= 1'b1;
    ratio <= 1'b0;
    cyc(10);
  endtask : t_loop

  task t_reset;
    frame(12'hfff);
    cyc(50);
    i_rst_n <= 1'b0;
    cyc(1);
    chk("rst state", {coll, line_n, txa, bclk, src}, 7'h20);
    cyc(2);
    i_rst_n <= 1'b1;
    cyc(5);
    chk("after reset", {coll, line_n, txa}, 3'b010);
  endtask : t_reset

  // --------------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------------
  initial begin
    cyc(9);
    chk("reset outputs", {coll, line_n, txa, bclk, src}, 7'h20);
    cyc(1);
    i_rst_n <= 1'b1;
    cyc(5);
    t_ratio;
    t_jabber_hb;
    t_freeze;
    t_echo_hold;
    t_no_coll(1'b1, 1'b1);
    t_no_coll(1'b0, 1'b0);
    t_loop;
    t_reset;
    end_sim;
  end
endmodule : tb
